// ===== hdl/cfbm_top.sv
// cpu status logic: status word, accumulator and temporary, alu
// command, register banks in ram, address decode and interrupt gate.
// assumes an axi4-lite master on the same clock, one write and one
// read under way at a time.
//
// Functional notes
// (RULE_01) half carry from bit 3 into 4
// (RULE_02) interrupt enable gates acceptance; cleared at reset
// (RULE_03) two-bit level; accept only higher priority
// (RULE_04) negative flag follows result bit 7
// (RULE_05) zero flag set on zero result
// (RULE_06) overflow flag on two's complement overflow
// (RULE_07) carry flag from carry/borrow out bit 7
// (RULE_08) shifts load carry with shifted-out bit
// (RULE_09) status word: bank pointer high, codes low
// (RULE_10) eight-register banks, sixteen on small ram
// (RULE_11) large ram allows thirty-two banks
// (RULE_12) decode peripherals and ram in 64k space
// (RULE_13) rom base depends on variant
// (RULE_14) vectors live at the top addresses
// (RULE_15) 16-bit accumulator, 8-bit ops use low byte
// (RULE_16) unnamed flags stay unchanged
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`include "cfbm_cfg.svh"
`default_nettype none
module cfbm_top (
    input wire logic clk, // 40 mhz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [15:0] psw_out, // current status word
    output logic irq_accept // pending request would be taken
);
    // ************************************
    // state
    // ************************************
    logic [15:0] psw_q, psw_d; // status word
    logic [15:0] acc_q, acc_d; // accumulator
    logic [15:0] tmp_q, tmp_d; // temporary
    logic [3:0] op_q; // last command code
    logic [2:0] cfg_q; // [0] large ram, [2:1] rom kind
    logic [15:0] adr_q; // address under decode
    logic [1:0] irq_q; // pending request level code
    logic [7:0] gpr_mem [0:255]; // 32 banks of 8 bytes

    logic aw_q; // write address held
    logic [7:0] awaddr_q; // held write address
    logic w_q; // write data held
    logic [31:0] wdata_q; // held write data
    logic [3:0] wstrb_q; // held byte enables
    logic bvalid_q; // write answer pending
    logic [1:0] bresp_q; // write answer code
    logic rvalid_q; // read answer pending
    logic [1:0] rresp_q; // read answer code
    logic [31:0] rdata_q; // read answer data

    cfbm_alu_if alu_bus (); // link to the alu

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // ************************************
    // write channel handshake
    // ************************************
    // address and data are taken in either order; commit needs both
    logic wr_fire; // both held, answer free
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign wr_fire = aw_q && w_q && !bvalid_q;

    // write decode, word aligned
    logic ws_psw, ws_acc, ws_tmp, ws_op, ws_cfg, ws_adr, ws_irq, ws_gpr;
    logic ws_hit; // mapped write
    assign ws_psw = (awaddr_q == `CFBM_OFF_PSW);
    assign ws_acc = (awaddr_q == `CFBM_OFF_ACC);
    assign ws_tmp = (awaddr_q == `CFBM_OFF_TMP);
    assign ws_op = (awaddr_q == `CFBM_OFF_OP);
    assign ws_cfg = (awaddr_q == `CFBM_OFF_CFG);
    assign ws_adr = (awaddr_q == `CFBM_OFF_ADR);
    assign ws_irq = (awaddr_q == `CFBM_OFF_IRQ);
    assign ws_gpr = (awaddr_q[7:5] == `CFBM_GPR_SEL) &&
                    (awaddr_q[1:0] == 2'h0);
    assign ws_hit = ws_psw | ws_acc | ws_tmp | ws_op | ws_cfg |
                    ws_adr | ws_irq | ws_gpr;

    // command write runs the alu in the same edge
    logic op_go; // alu command issued
    assign op_go = wr_fire && ws_op && wstrb_q[0];

    // hold address and data until commit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_q <= 1'b0;
        end
    end

    // write answer; unmapped offsets get slverr
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CFBM_RESP_OK;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= ws_hit ? `CFBM_RESP_OK : `CFBM_RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ************************************
    // alu hookup
    // ************************************
    // 8-bit ops read and write only the low bytes
    assign alu_bus.op = cfbm_pkg::cfbm_op_t'(wdata_q[3:0]);
    assign alu_bus.a = acc_q[7:0]; // RULE_15
    assign alu_bus.b = tmp_q[7:0]; // RULE_15
    assign alu_bus.cin = psw_q[`CFBM_BIT_C];

    cfbm_alu u_alu (
        .bus (alu_bus)
    );

    // ************************************
    // status word next value
    // ************************************
    // a direct write wins over a flag update in the same edge
    always_comb begin
        psw_d = psw_q;
        if (wr_fire && ws_psw) begin
            psw_d = merge16(psw_q, wdata_q, wstrb_q); // RULE_09
        end else if (op_go) begin
            if (alu_bus.upd_h) begin
                psw_d[`CFBM_BIT_H] = alu_bus.h; // RULE_01
            end
            if (alu_bus.upd_n) begin
                psw_d[`CFBM_BIT_N] = alu_bus.n; // RULE_04
            end
            if (alu_bus.upd_z) begin
                psw_d[`CFBM_BIT_Z] = alu_bus.z; // RULE_05
            end
            if (alu_bus.upd_v) begin
                psw_d[`CFBM_BIT_V] = alu_bus.v; // RULE_06
            end
            if (alu_bus.upd_c) begin
                psw_d[`CFBM_BIT_C] = alu_bus.c; // RULE_07 RULE_08
            end
        end
    end

    // accumulator: alu result lands in low byte, high byte kept
    always_comb begin
        acc_d = acc_q;
        if (wr_fire && ws_acc) begin
            acc_d = merge16(acc_q, wdata_q, wstrb_q);
        end else if (op_go && alu_bus.wr_res) begin
            acc_d = {acc_q[15:8], alu_bus.res}; // RULE_15
        end
    end
    assign tmp_d = (wr_fire && ws_tmp) ? merge16(tmp_q, wdata_q, wstrb_q)
                                        : tmp_q;

    // status reset leaves interrupts disabled, level lowest
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psw_q <= `CFBM_PSW_RST; // RULE_02
            acc_q <= 16'h0000;
            tmp_q <= 16'h0000;
        end else begin
            psw_q <= psw_d;
            acc_q <= acc_d;
            tmp_q <= tmp_d;
        end
    end
    assign psw_out = psw_q;

    // small control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 4'h0;
            cfg_q <= 3'h0;
            adr_q <= 16'h0000;
            irq_q <= 2'h3;
        end else if (wr_fire) begin
            if (op_go) begin
                op_q <= wdata_q[3:0];
            end
            if (ws_cfg && wstrb_q[0]) begin
                cfg_q <= wdata_q[2:0];
            end
            if (ws_adr) begin
                adr_q <= merge16(adr_q, wdata_q, wstrb_q);
            end
            if (ws_irq && wstrb_q[0]) begin
                irq_q <= wdata_q[1:0];
            end
        end
    end

    // ************************************
    // register banks
    // ************************************
    // small ram ignores the top pointer bit, so only 16 banks reach
    logic [4:0] bank; // active bank number
    logic [7:0] wr_gpr_at; // byte index for writes
    logic [7:0] rd_gpr_at; // byte index for reads
    assign bank = cfg_q[0] ? psw_q[`CFBM_RP_LSB+4:`CFBM_RP_LSB] // RULE_11
                           : {1'b0, psw_q[`CFBM_RP_LSB+3:`CFBM_RP_LSB]}; // RULE_10
    assign wr_gpr_at = {bank, awaddr_q[4:2]}; // RULE_10
    assign rd_gpr_at = {bank, s_axi_araddr[4:2]};

    // memory array has no reset: contents undefined until written
    always_ff @(posedge clk) begin
        if (wr_fire && ws_gpr && wstrb_q[0]) begin
            gpr_mem[wr_gpr_at] <= wdata_q[7:0];
        end
    end

    // ************************************
    // address decode
    // ************************************
    logic [15:0] ram_top; // last ram byte of variant
    logic [15:0] rom_base; // first rom byte of variant
    logic in_periph, in_ram, in_rom, in_vec; // region hits
    cfbm_pkg::cfbm_region_t region; // decode answer
    assign ram_top = cfg_q[0] ? `CFBM_RAM_TOP_L : `CFBM_RAM_TOP_S;
    assign rom_base = (cfg_q[2:1] == 2'h0) ? `CFBM_ROM_MASK : // RULE_13
                      (cfg_q[2:1] == 2'h1) ? `CFBM_ROM_OTP : `CFBM_ROM_PIGGY;
    assign in_periph = (adr_q <= `CFBM_PERIPH_TOP); // RULE_12
    assign in_ram = (adr_q >= `CFBM_RAM_BASE) && (adr_q <= ram_top); // RULE_12
    assign in_rom = (adr_q >= rom_base); // RULE_13
    assign in_vec = (adr_q >= `CFBM_VEC_BASE); // RULE_14
    assign region = in_periph ? cfbm_pkg::RG_PERIPH :
                    in_ram ? cfbm_pkg::RG_RAM :
                    in_vec ? cfbm_pkg::RG_VECTOR :
                    in_rom ? cfbm_pkg::RG_ROM : cfbm_pkg::RG_NONE;

    // ************************************
    // interrupt gate
    // ************************************
    // codes 00 and 01 are both level 1; smaller level is higher priority
    logic [1:0] cur_lvl, req_lvl; // levels 1..3
    assign cur_lvl = psw_q[`CFBM_BIT_ILH] ? {1'b1, psw_q[`CFBM_BIT_ILL]}
                                          : 2'h1; // RULE_03
    assign req_lvl = irq_q[1] ? {1'b1, irq_q[0]} : 2'h1; // RULE_03
    assign irq_accept = psw_q[`CFBM_BIT_I] && (req_lvl < cur_lvl); // RULE_02 RULE_03

    // ************************************
    // read channel
    // ************************************
    logic [31:0] rd_mux; // selected read word
    logic rd_hit; // mapped read
    logic rs_gpr; // bank register read
    assign rs_gpr = (s_axi_araddr[7:5] == `CFBM_GPR_SEL) &&
                    (s_axi_araddr[1:0] == 2'h0);
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CFBM_OFF_PSW: rd_mux = {16'h0000, psw_q};
            `CFBM_OFF_ACC: rd_mux = {16'h0000, acc_q};
            `CFBM_OFF_TMP: rd_mux = {16'h0000, tmp_q};
            `CFBM_OFF_OP: rd_mux = {28'h0, op_q};
            `CFBM_OFF_CFG: rd_mux = {29'h0, cfg_q};
            `CFBM_OFF_ADR: rd_mux = {13'h0, region, adr_q};
            `CFBM_OFF_IRQ: rd_mux = {29'h0, irq_accept, irq_q};
            default: begin
                if (rs_gpr) begin
                    rd_mux = {24'h0, gpr_mem[rd_gpr_at]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // one read at a time; address taken only with no answer pending
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= `CFBM_RESP_OK;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? `CFBM_RESP_OK : `CFBM_RESP_ERR;
            rdata_q <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule : cfbm_top
`default_nettype wire

// ===== hdl/cfbm_cfg.svh
// offsets, field positions, reset values and address limits of the
// cpu flags / bank / memory map block.
// assumes byte addressing on an 8-bit axi4-lite address.
`ifndef CFBM_CFG_SVH
`define CFBM_CFG_SVH

// ********
// register byte offsets
// ********
`define CFBM_OFF_PSW 8'h00
`define CFBM_OFF_ACC 8'h04
`define CFBM_OFF_TMP 8'h08
`define CFBM_OFF_OP 8'h0c
`define CFBM_OFF_CFG 8'h10
`define CFBM_OFF_ADR 8'h14
`define CFBM_OFF_IRQ 8'h18
`define CFBM_GPR_SEL 3'h1

// ********
// status word layout and reset
// ********
`define CFBM_PSW_RST 16'h0030
`define CFBM_BIT_H 7
`define CFBM_BIT_I 6
`define CFBM_BIT_ILH 5
`define CFBM_BIT_ILL 4
`define CFBM_BIT_N 3
`define CFBM_BIT_Z 2
`define CFBM_BIT_V 1
`define CFBM_BIT_C 0
`define CFBM_RP_MSB 15
`define CFBM_RP_LSB 8

// ********
// memory map limits
// ********
`define CFBM_PERIPH_TOP 16'h007f
`define CFBM_RAM_BASE 16'h0080
`define CFBM_RAM_TOP_S 16'h027f
`define CFBM_RAM_TOP_L 16'h047f
`define CFBM_ROM_MASK 16'he000
`define CFBM_ROM_OTP 16'hc000
`define CFBM_ROM_PIGGY 16'h8000
`define CFBM_VEC_BASE 16'hffc0

// ********
// bus answers
// ********
`define CFBM_RESP_OK 2'h0
`define CFBM_RESP_ERR 2'h2

`endif

// ===== hdl/cfbm_pkg.sv
// types shared by the flags block and its alu.
// assumes nothing beyond a systemverilog compiler.
`default_nettype none
package cfbm_pkg;
    // alu operations, 4-bit command code
    typedef enum logic [3:0] {
        OP_ADD  = 4'h0,
        OP_ADDC = 4'h1,
        OP_SUB  = 4'h2,
        OP_SUBC = 4'h3,
        OP_AND  = 4'h4,
        OP_OR   = 4'h5,
        OP_XOR  = 4'h6,
        OP_ROLC = 4'h7,
        OP_RORC = 4'h8,
        OP_CMP  = 4'h9
    } cfbm_op_t;

    // address decode answer
    typedef enum logic [2:0] {
        RG_PERIPH = 3'h0,
        RG_RAM    = 3'h1,
        RG_ROM    = 3'h2,
        RG_VECTOR = 3'h3,
        RG_NONE   = 3'h4
    } cfbm_region_t;
endpackage : cfbm_pkg
`default_nettype wire

// ===== hdl/cfbm_alu_if.sv
// carrier between the flags core and its alu.
// assumes both ends sit on the same clock; all signals combinational.
`default_nettype none
interface cfbm_alu_if;
    cfbm_pkg::cfbm_op_t op; // operation code
    logic [7:0] a; // low byte of accumulator
    logic [7:0] b; // low byte of temporary
    logic cin; // carry flag in
    logic [7:0] res; // result byte
    logic wr_res; // result goes to accumulator
    logic h, n, z, v, c; // flag values
    logic upd_h, upd_n, upd_z, upd_v, upd_c; // flag write enables

    modport core (output op, a, b, cin,
                  input res, wr_res, h, n, z, v, c,
                  input upd_h, upd_n, upd_z, upd_v, upd_c);
    modport alu (input op, a, b, cin,
                 output res, wr_res, h, n, z, v, c,
                 output upd_h, upd_n, upd_z, upd_v, upd_c);
endinterface : cfbm_alu_if
`default_nettype wire

// ===== hdl/cfbm_alu.sv
// 8-bit alu: result byte and the flag values and enables per operation.
// assumes operands are the low bytes of the 16-bit registers.
`default_nettype none
module cfbm_alu (
    cfbm_alu_if.alu bus // operands in, result and flags out
);
    // ************************************
    // arithmetic terms
    // ************************************
    logic [8:0] sum9; // byte add with carry out
    logic [4:0] sumh; // nibble add, carry into bit 4
    logic [8:0] dif9; // byte subtract with borrow out
    logic [4:0] difh; // nibble subtract, borrow into bit 4
    logic ci; // carry used by this op
    logic is_add; // add family
    logic is_sub; // subtract family

    assign is_add = (bus.op == cfbm_pkg::OP_ADD) ||
                    (bus.op == cfbm_pkg::OP_ADDC);
    assign is_sub = (bus.op == cfbm_pkg::OP_SUB) ||
                    (bus.op == cfbm_pkg::OP_SUBC) ||
                    (bus.op == cfbm_pkg::OP_CMP);
    assign ci = ((bus.op == cfbm_pkg::OP_ADDC) ||
                 (bus.op == cfbm_pkg::OP_SUBC)) ? bus.cin : 1'b0;
    assign sum9 = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, ci};
    assign sumh = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, ci};
    assign dif9 = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, ci};
    assign difh = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, ci};

    // ************************************
    // per-operation outputs
    // ************************************
    // flags not named by an op keep their enable low
    always_comb begin
        bus.res = bus.a;
        bus.wr_res = 1'b0;
        bus.h = 1'b0;
        bus.v = 1'b0;
        bus.c = 1'b0;
        {bus.upd_h, bus.upd_n, bus.upd_z, bus.upd_v, bus.upd_c} = 5'h00; // RULE_16
        case (bus.op)
            cfbm_pkg::OP_ADD, cfbm_pkg::OP_ADDC: begin
                bus.res = sum9[7:0];
                bus.wr_res = 1'b1;
                bus.h = sumh[4]; // RULE_01
                bus.c = sum9[8]; // RULE_07
                bus.v = (bus.a[7] == bus.b[7]) && (sum9[7] != bus.a[7]); // RULE_06
                {bus.upd_h, bus.upd_n, bus.upd_z, bus.upd_v, bus.upd_c} = 5'h1f;
            end
            cfbm_pkg::OP_SUB, cfbm_pkg::OP_SUBC, cfbm_pkg::OP_CMP: begin
                bus.res = dif9[7:0];
                bus.wr_res = (bus.op != cfbm_pkg::OP_CMP); // compare keeps a
                bus.h = difh[4]; // RULE_01
                bus.c = dif9[8]; // RULE_07
                bus.v = (bus.a[7] != bus.b[7]) && (dif9[7] != bus.a[7]); // RULE_06
                {bus.upd_h, bus.upd_n, bus.upd_z, bus.upd_v, bus.upd_c} = 5'h1f;
            end
            cfbm_pkg::OP_AND, cfbm_pkg::OP_OR, cfbm_pkg::OP_XOR: begin
                // logic ops touch n, z and clear v only
                if (bus.op == cfbm_pkg::OP_AND) begin
                    bus.res = bus.a & bus.b;
                end else if (bus.op == cfbm_pkg::OP_OR) begin
                    bus.res = bus.a | bus.b;
                end else begin
                    bus.res = bus.a ^ bus.b;
                end
                bus.wr_res = 1'b1;
                {bus.upd_n, bus.upd_z, bus.upd_v} = 3'h7;
            end
            cfbm_pkg::OP_ROLC: begin
                bus.res = {bus.a[6:0], bus.cin};
                bus.wr_res = 1'b1;
                bus.c = bus.a[7]; // RULE_08
                {bus.upd_n, bus.upd_z, bus.upd_c} = 3'h7;
            end
            cfbm_pkg::OP_RORC: begin
                bus.res = {bus.cin, bus.a[7:1]};
                bus.wr_res = 1'b1;
                bus.c = bus.a[0]; // RULE_08
                {bus.upd_n, bus.upd_z, bus.upd_c} = 3'h7;
            end
            default: begin
                bus.res = bus.a; // unknown code: no effect
            end
        endcase
    end

    assign bus.n = bus.res[7]; // RULE_04
    assign bus.z = (bus.res == 8'h00); // RULE_05
endmodule : cfbm_alu
`default_nettype wire

// ===== bench/cfbm_top_properties.sv
// checker: bus answers, status word and interrupt gate of cfbm_top.
// assumes it is bound into cfbm_top and sees only its ports.
`default_nettype none
module cfbm_top_chk (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // write answer
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [15:0] psw_out, // status word
    input wire logic irq_accept // interrupt gate
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // both halves taken at one edge, no answer pending
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid;
    irq_gate_a: assert property (irq_accept |-> psw_out[6])
        else $error("interrupt taken while disabled");
    irq_level_a: assert property (irq_accept |-> psw_out[5])
        else $error("interrupt taken at top level");
    // flags move only with a committed write, never on their own
    psw_still_a: assert property (
        !$stable(psw_out) |-> $rose(s_axi_bvalid))
        else $error("status word moved without a write");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("ar ready wrong");
    w_answer_a: assert property (wr_take |=> !s_axi_awready ##1
        s_axi_bvalid) else $error("write answer late");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    cover property (irq_accept);
    cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h2);
    cover property (!$stable(psw_out));
endmodule : cfbm_top_chk
bind cfbm_top cfbm_top_chk chk_u (.*);
`default_nettype wire

// ===== bench/test_cfbm_top.sv
// bench: register bus tasks driving the status block.
// assumes the design files and the checker are compiled first.
`include "cfbm_cfg.svh"
`default_nettype none
module test_cfbm_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // signals
    // ********
    logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_accept;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] psw_out;
    logic [31:0] rv; // raw read word
    logic [1:0] rr; // raw read answer
    int mismatches, comparisons;
    // op, a, b, psw in, result, psw out
    logic [59:0] alu [13] = '{60'h0_08_08_0030_10_00b0,
        60'h0_80_80_0030_00_0037, 60'h0_7f_01_0030_80_00ba,
        60'h7_81_00_0030_02_0031, 60'h4_f0_0f_05b3_00_05b5,
        60'h2_00_01_0030_ff_00b9, 60'h8_01_00_0031_80_0039,
        60'h1_0f_00_0031_10_00b0, 60'h9_05_05_0030_05_0034,
        60'h3_10_01_0031_0e_00b0, 60'h5_80_01_0033_81_0039,
        60'h6_5a_5a_00b0_00_00b4, 60'ha_12_34_0030_12_0030};
    // psw, request code, accept
    logic [23:0] irq [7] = '{24'h0070_2_1, 24'h0070_3_0, 24'h0030_0_0,
        24'h0060_0_1, 24'h0060_1_1, 24'h0060_2_0, 24'h0050_0_0};
    // cfg, address, region
    logic [23:0] map [12] = '{24'h0_007f_0, 24'h0_0080_1, 24'h0_027f_1,
        24'h0_0280_4, 24'h1_047f_1, 24'h0_e000_2, 24'h0_dfff_4,
        24'h2_c000_2, 24'h0_c000_4, 24'h4_8000_2, 24'h0_ffc0_3,
        24'h0_ffbf_2};
    cfbm_top dut_u (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic stop_test;
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    // a hung handshake ends the run
    task automatic guard(input int n);
        if (n > 40) begin
            mismatches++;
            stop_test();
        end
    endtask : guard
    // ready is looked at mid-cycle so the edge decides, not the race
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
            input logic [1:0] r = 2'h0);
        bit done;
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int n = 0; !done; n++) begin
            guard(n);
            @(negedge clk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                done = 1'b1;
                chk("bresp", r, s_axi_bresp);
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bit done;
        logic ar, v;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int n = 0; !done; n++) begin
            guard(n);
            @(negedge clk);
            {ar, v, rv, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata,
                s_axi_rresp};
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) begin
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
    task automatic rchk(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
        chk("rresp", 2'h0, rr);
    endtask : rchk
    // ********
    // sequence
    // ********
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, rst_n} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk("irq", 1'b0, irq_accept);
        rchk("psw", `CFBM_OFF_PSW, 32'h30);
        foreach (alu[i]) begin
            wr(`CFBM_OFF_PSW, alu[i][39:24]);
            wr(`CFBM_OFF_ACC, {8'h5a, alu[i][55:48]});
            wr(`CFBM_OFF_TMP, {8'h00, alu[i][47:40]});
            wr(`CFBM_OFF_OP, {12'h0, alu[i][59:56]});
            rchk("acc", `CFBM_OFF_ACC, {16'h5a, alu[i][23:16]});
            rchk("flags", `CFBM_OFF_PSW, alu[i][15:0]);
            chk("psw_out", alu[i][15:0], psw_out);
        end
        foreach (irq[i]) begin
            wr(`CFBM_OFF_PSW, irq[i][23:8]);
            wr(`CFBM_OFF_IRQ, {14'h0, irq[i][5:4]});
            chk("accept", irq[i][0], irq_accept);
        end
        wr(`CFBM_OFF_PSW, 16'h0000);
        wr(8'h24, 16'h11);
        wr(`CFBM_OFF_PSW, 16'h0100);
        wr(8'h24, 16'h22);
        rchk("bank1", 8'h24, 32'h22);
        wr(`CFBM_OFF_PSW, 16'h1000);
        rchk("bank16s", 8'h24, 32'h11);
        wr(`CFBM_OFF_CFG, 16'h1);
        wr(8'h24, 16'h33);
        wr(`CFBM_OFF_PSW, 16'h0000);
        rchk("bank0l", 8'h24, 32'h11);
        foreach (map[i]) begin
            wr(`CFBM_OFF_CFG, {12'h0, map[i][23:20]});
            wr(`CFBM_OFF_ADR, map[i][19:4]);
            rchk("adr", `CFBM_OFF_ADR, {map[i][2:0], map[i][19:4]});
        end
        wr(8'h1c, 16'h1, `CFBM_RESP_ERR);
        rd(8'h1c);
        chk("unmapped", `CFBM_RESP_ERR, rr);
        chk("unmapped data", 32'h0, rv);
        stop_test();
    end
endmodule : test_cfbm_top
`default_nettype wire
